//--- src/epcb_bank.sv
// eeprom-loaded per-port configuration register bank
//
// Implementation choice: the strobed register port.
`include "epcb_defines.svh"

module epcb_bank #(
  parameter logic [15:0] SIGNATURE = `EPCB_SIG_DEFAULT // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output epcb_pkg::epcb_ee_req_t ee_req,
  input wire epcb_pkg::epcb_ee_rsp_t ee_rsp,
  input wire logic crossover_strap,
  input wire logic port7_fibre_strap,
  input wire logic tag_mode,
  output logic cfg_done,
  output logic sig_match,
  output epcb_pkg::epcb_port_eff_t [8:0] port_eff
);
  epcb_pkg::epcb_regs_t s_q;
  epcb_pkg::epcb_regs_t s_d;

  // next-state logic: loader, host access, effective settings
  always_comb begin
    logic [15:0] w;
    logic [3:0] hidx;
    w = 16'h0000;
    hidx = 4'h0;
    s_d = s_q;
    // straps pass two flops before anything looks at them
    s_d.strap_meta = {crossover_strap, port7_fibre_strap};
    s_d.strap_sync = s_q.strap_meta;

    // host writes land before the loader so an eeprom word wins a clash
    if (reg_wr && reg_addr >= `EPCB_OFS_CFG_FIRST && reg_addr <= `EPCB_OFS_CFG_LAST) begin
      hidx = 4'(reg_addr - `EPCB_OFS_CFG_FIRST);
      s_d.cfg[hidx] = reg_wdata;
    end
    // a write to the signature offset falls through unmapped, no effect

    // read data valid the cycle after the strobe, zero when unmapped
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == `EPCB_OFS_SIG) begin
        s_d.rdata = SIGNATURE;
      end else if (reg_addr >= `EPCB_OFS_CFG_FIRST && reg_addr <= `EPCB_OFS_CFG_LAST) begin
        s_d.rdata = s_q.cfg[4'(reg_addr - `EPCB_OFS_CFG_FIRST)];
      end
    end

    case (s_q.st)
      epcb_pkg::EPCB_ST_SYNC: begin
        // wait for the synchroniser to fill, then freeze the straps once
        if (s_q.sync_cnt == `EPCB_SYNC_WAIT) begin
          s_d.crossover_strap = s_q.strap_sync[1];
          s_d.port7_fibre_strap = s_q.strap_sync[0];
          s_d.widx = 4'h0;
          s_d.st = epcb_pkg::EPCB_ST_SIG_REQ;
        end else begin
          s_d.sync_cnt = s_q.sync_cnt + `EPCB_CNT_STEP;
        end
      end
      epcb_pkg::EPCB_ST_SIG_REQ: begin
        s_d.st = epcb_pkg::EPCB_ST_SIG_WAIT; // word 0 asked first
      end
      epcb_pkg::EPCB_ST_SIG_WAIT: begin
        if (ee_rsp.valid) begin
          if (ee_rsp.data == SIGNATURE) begin
            s_d.sig_match = 1'b1;
            s_d.widx = `EPCB_WIDX_FIRST;
            s_d.st = epcb_pkg::EPCB_ST_CFG_REQ;
          end else begin
            // no further words read, reset defaults stay
            s_d.loaded = 1'b1;
            s_d.st = epcb_pkg::EPCB_ST_RUN;
          end
        end
      end
      epcb_pkg::EPCB_ST_CFG_REQ: begin
        s_d.st = epcb_pkg::EPCB_ST_CFG_WAIT;
      end
      epcb_pkg::EPCB_ST_CFG_WAIT: begin
        if (ee_rsp.valid) begin
          s_d.cfg[4'(s_q.widx - `EPCB_WIDX_STEP)] = ee_rsp.data;
          if (s_q.widx == `EPCB_WIDX_LAST) begin
            s_d.loaded = 1'b1;
            s_d.st = epcb_pkg::EPCB_ST_RUN;
          end else begin
            s_d.widx = s_q.widx + `EPCB_WIDX_STEP;
            s_d.st = epcb_pkg::EPCB_ST_CFG_REQ;
          end
        end
      end
      epcb_pkg::EPCB_ST_RUN: begin
        s_d.st = epcb_pkg::EPCB_ST_RUN;
      end
      default: begin
        s_d.st = epcb_pkg::EPCB_ST_SYNC;
      end
    endcase

    // effective settings, registered so the core sees clean flops
    for (int p = 0; p < `EPCB_NPORTS; p++) begin
      w = s_q.cfg[p];
      s_d.eff[p].auto_mdix = s_q.crossover_strap | w[`EPCB_B_XOVER];
      s_d.eff[p].fibre = 1'b0;
      if (p == `EPCB_FIBRE_PORT) begin
        s_d.eff[p].fibre = s_q.port7_fibre_strap | w[`EPCB_B_FIBRE];
      end
      s_d.eff[p].port_vlan_low_bits = w[`EPCB_B_VLAN_HI:`EPCB_B_VLAN_LO];
      // any nonzero number goes to the high queue, only two exist
      s_d.eff[p].queue_hi = (w[`EPCB_B_PRIO_HI:`EPCB_B_PRIO_LO] != `EPCB_PRIO_Q0);
      if (w[`EPCB_B_PORT_PRIO] || !tag_mode) begin
        s_d.eff[p].pri_src = epcb_pkg::EPCB_PRI_PORT;
      end else if (w[`EPCB_B_TOS_FIRST]) begin
        s_d.eff[p].pri_src = epcb_pkg::EPCB_PRI_TOS;
      end else begin
        s_d.eff[p].pri_src = epcb_pkg::EPCB_PRI_VLAN;
      end
      // expansion port is always enabled, its port-off bit is ignored
      s_d.eff[p].enabled = (p == `EPCB_EXP_PORT) ? 1'b1 : !w[`EPCB_B_PORT_OFF];
      s_d.eff[p].tagged_port = w[`EPCB_B_TAGGED];
      {s_d.eff[p].duplex_cap, s_d.eff[p].speed_cap, s_d.eff[p].autoneg_cap,
       s_d.eff[p].pause_cap} = w[`EPCB_B_CAP_HI:`EPCB_B_CAP_LO];
    end
  end

  // state register, defaults on reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.cfg <= {`EPCB_NPORTS{`EPCB_CFG_DEFAULT}};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata = s_q.rdata;
  assign ee_req.req = (s_q.st == epcb_pkg::EPCB_ST_SIG_REQ) || (s_q.st == epcb_pkg::EPCB_ST_CFG_REQ);
  assign ee_req.addr = {4'h0, s_q.widx};
  assign cfg_done = s_q.loaded;
  assign sig_match = s_q.sig_match;
  assign port_eff = s_q.eff;
endmodule // epcb_bank

//--- inc/epcb_defines.svh
// offsets, field positions, reset values and timing counts of the port config bank
`ifndef EPCB_DEFINES_SVH
`define EPCB_DEFINES_SVH
`define EPCB_NPORTS 9
`define EPCB_FIBRE_PORT 7
`define EPCB_EXP_PORT 8
`define EPCB_OFS_SIG 8'h00
`define EPCB_OFS_CFG_FIRST 8'h01
`define EPCB_OFS_CFG_LAST 8'h09
`define EPCB_WIDX_FIRST 4'h1
`define EPCB_WIDX_LAST 4'h9
`define EPCB_WIDX_STEP 4'h1
`define EPCB_CFG_DEFAULT 16'h040f
`define EPCB_SIG_DEFAULT 16'h5a3c
`define EPCB_SYNC_WAIT 2'h2
`define EPCB_CNT_STEP 2'h1
`define EPCB_B_XOVER 15
`define EPCB_B_FIBRE 14
`define EPCB_B_VLAN_HI 13
`define EPCB_B_VLAN_LO 10
`define EPCB_B_PRIO_HI 9
`define EPCB_B_PRIO_LO 8
`define EPCB_B_PORT_PRIO 7
`define EPCB_B_TOS_FIRST 6
`define EPCB_B_PORT_OFF 5
`define EPCB_B_TAGGED 4
`define EPCB_B_CAP_HI 3
`define EPCB_B_CAP_LO 0
`define EPCB_PRIO_Q0 2'h0
`endif

//--- inc/epcb_pkg.sv
// types of the port config bank
package epcb_pkg;
  typedef enum logic [2:0] {
    EPCB_ST_SYNC = 3'b000,
    EPCB_ST_SIG_REQ = 3'b001,
    EPCB_ST_SIG_WAIT = 3'b010,
    EPCB_ST_CFG_REQ = 3'b011,
    EPCB_ST_CFG_WAIT = 3'b100,
    EPCB_ST_RUN = 3'b101
  } epcb_state_t;

  typedef enum logic [1:0] {
    EPCB_PRI_PORT = 2'b00,
    EPCB_PRI_VLAN = 2'b01,
    EPCB_PRI_TOS = 2'b10
  } epcb_pri_src_t;

  // effective per-port settings handed to the switch core
  typedef struct packed {
    logic auto_mdix;
    logic fibre;
    logic [3:0] port_vlan_low_bits;
    logic queue_hi;
    epcb_pri_src_t pri_src;
    logic enabled;
    logic tagged_port;
    logic duplex_cap;
    logic speed_cap;
    logic autoneg_cap;
    logic pause_cap;
  } epcb_port_eff_t;

  // request toward the eeprom word reader
  typedef struct packed {
    logic req;
    logic [7:0] addr;
  } epcb_ee_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } epcb_ee_rsp_t;

  // whole state of the bank
  typedef struct packed {
    epcb_state_t st;
    logic [1:0] sync_cnt;
    logic [3:0] widx;
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic crossover_strap;
    logic port7_fibre_strap;
    logic sig_match;
    logic loaded;
    logic [15:0] rdata;
    logic [8:0][15:0] cfg;
    epcb_port_eff_t [8:0] eff;
  } epcb_regs_t;
endpackage

//--- tb/epcb_ee_model.sv
// behavioural config eeprom answering word requests
module epcb_ee_model (
  input wire logic sys_clk,
  input wire epcb_pkg::epcb_ee_req_t ee_req,
  output epcb_pkg::epcb_ee_rsp_t ee_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:9];
  logic [15:0] word_q = 16'h0000;
  logic [2:0] cnt_q = 3'h0;
  initial ee_rsp = '0;
  // odd words answer slowly; idle data toggles so stale data is never trusted
  always @(posedge sys_clk) begin
    ee_rsp.valid <= cnt_q == 3'h1;
    ee_rsp.data <= cnt_q == 3'h1 ? word_q : ~ee_rsp.data;
    if (ee_req.req) begin
      cnt_q <= ee_req.addr[0] ? 3'h5 : 3'h1;
      word_q <= mem[ee_req.addr[3:0]];
    end else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
endmodule // epcb_ee_model

//--- tb/epcb_checker.sv
// concurrent checks on the port config bank ports
module epcb_checker #(
  parameter logic [15:0] SIGNATURE = 16'h5a3c
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire epcb_pkg::epcb_ee_req_t ee_req,
  input wire epcb_pkg::epcb_ee_rsp_t ee_rsp,
  input wire logic tag_mode,
  input wire logic cfg_done,
  input wire logic sig_match,
  input wire epcb_pkg::epcb_port_eff_t [8:0] port_eff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic ok_q;
  // set once word 0 carried the signature
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ok_q <= 1'b0;
    else if (ee_rsp.valid && ee_req.addr == 8'h00) ok_q <= ee_rsp.data == SIGNATURE;
  end
  // host write once the load is over
  sequence s_wr(a, c);
    reg_wr && reg_addr == a && cfg_done && c;
  endsequence
  a_sig_first: assert property (ee_req.req && ee_req.addr != 8'h00 |-> ok_q)
    else $error("word read before signature");
  a_mis_done: assert property (ee_rsp.valid && ee_req.addr == 8'h00 && ee_rsp.data != SIGNATURE
    |-> ##[1:3] cfg_done && !sig_match) else $error("mismatch not ended");
  a_sig_ro: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == SIGNATURE)
    else $error("signature read");
  a_cfg_fields: assert property (s_wr(8'h03, 1'b1) |-> ##2 port_eff[2][12:9] == 4'($past(reg_wdata, 2) >> 10)
    && port_eff[2][4:0] == 5'($past(reg_wdata, 2))) else $error("fields");
  a_port_off: assert property (s_wr(8'h04, 1'b1) |-> ##2 port_eff[3].enabled != $past(reg_wdata[5], 2))
    else $error("port off");
  a_pri_port: assert property (s_wr(8'h05, reg_wdata[7] || !tag_mode) |-> ##2 port_eff[4].pri_src == 2'h0)
    else $error("port priority");
  a_pri_tos: assert property (s_wr(8'h05, !reg_wdata[7] && tag_mode)
    |-> ##2 port_eff[4].pri_src == {$past(reg_wdata[6], 2), !$past(reg_wdata[6], 2)}) else $error("tos");
  a_ee_copy: assert property (ee_rsp.valid && ok_q && ee_req.addr == 8'h03
    |-> ##2 port_eff[2][4:0] == 5'($past(ee_rsp.data, 2))) else $error("copy");
endmodule // epcb_checker
bind epcb_bank epcb_checker #(.SIGNATURE(SIGNATURE)) u_epcb_checker (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .ee_req, .ee_rsp, .tag_mode, .cfg_done, .sig_match, .port_eff);

//--- tb/epcb_bank_tb_top.sv
// self-checking bench of the port config bank
module epcb_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SIG = 16'h1c2d; // arbitrary signature value
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tag_mode = 1'b0;
  logic crossover_strap = 1'b0, port7_fibre_strap = 1'b0, cfg_done, sig_match;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  epcb_pkg::epcb_ee_req_t ee_req;
  epcb_pkg::epcb_ee_rsp_t ee_rsp;
  epcb_pkg::epcb_port_eff_t [8:0] port_eff;
  int err_total = 0, cmp_count = 0;
  // 125 MHz core clock
  always #4 sys_clk = ~sys_clk;
  epcb_bank #(.SIGNATURE(SIG)) u_epcb_bank (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ee_req, .ee_rsp, .crossover_strap, .port7_fibre_strap, .tag_mode, .cfg_done, .sig_match, .port_eff);
  epcb_ee_model u_epcb_ee_model (.sys_clk, .ee_req, .ee_rsp);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // write strobe, then wait until the port view has settled
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // read strobe, data judged in the following cycle only
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // reset with both straps at x, then wait for the load to end
  task automatic boot(input logic [15:0] s, input logic x);
    int n;
    sys_rst <= 1'b1;
    crossover_strap <= x;
    port7_fibre_strap <= x;
    u_epcb_ee_model.mem[0] = s;
    for (n = 1; n < 10; n++) u_epcb_ee_model.mem[n] = 16'(n * 16'h1b35);
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 200 && cfg_done !== 1'b1; n++) @(negedge sys_clk);
    if (n == 200) begin
      err_total++;
      finish_test();
    end
  endtask
  // good image with straps high; straps dropped later must not count
  task automatic t_match();
    int n;
    boot(SIG, 1'b1);
    chk(sig_match, 1'b1);
    for (n = 1; n < 10; n++) rc(8'(n), u_epcb_ee_model.mem[n]);
    for (n = 0; n < 9; n++) chk(port_eff[n].auto_mdix, 1'b1);
    crossover_strap <= 1'b0;
    port7_fibre_strap <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(8'h08, 16'h0000);
    chk(port_eff[7][14:13], 2'b11);
  endtask
  // bad signature: defaults kept, signature word read-only
  task automatic t_mismatch();
    int n;
    boot(~SIG, 1'b0);
    chk(sig_match, 1'b0);
    for (n = 1; n < 10; n++) rc(8'(n), 16'h040f);
    chk(port_eff[7], 16'h022f);
    wr(8'h00, 16'h0000);
    rc(8'h00, SIG);
    rc(8'h0a, 16'h0000);
  endtask
  // field decoding of host writes with straps low
  task automatic t_fields();
    int n;
    for (n = 0; n < 4; n++) begin
      wr(8'h03, 16'(n) << 8);
      chk(port_eff[2].queue_hi, n != 0);
    end
    for (n = 0; n < 8; n++) begin
      tag_mode <= n[2];
      wr(8'h05, 16'(n % 4) << 6);
      chk(port_eff[4].pri_src, n[2] && !n[1] ? (n[0] ? 2'h2 : 2'h1) : 2'h0);
    end
    wr(8'h02, 16'hc000);
    chk({port_eff[1].auto_mdix, port_eff[1].fibre}, 2'b10);
    wr(8'h08, 16'h4000);
    chk(port_eff[7].fibre, 1'b1);
    wr(8'h04, 16'h0020);
    chk(port_eff[3].enabled, 1'b0);
    wr(8'h09, 16'h0020);
    chk(port_eff[8].enabled, 1'b1);
  endtask
  // the three runs, then the verdict
  initial begin
    t_match();
    t_mismatch();
    t_fields();
    finish_test();
  end
endmodule // epcb_bank_tb_top
